//--- hw/dlsm_pkg.sv
/*
 * Package for the DTE port lead and status monitor: register map, field
 * positions, reset values, state encodings and timing constants.
 * Assumes a 32-bit APB register bus and a single 125 MHz system clock.
 */
package dlsm_pkg;

	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam logic [11:0] DLSM_OFS_CTRL     = 12'h000;
	localparam logic [11:0] DLSM_OFS_PORTCFG  = 12'h004;
	localparam logic [11:0] DLSM_OFS_LEADS    = 12'h008;
	localparam logic [11:0] DLSM_OFS_DSXST    = 12'h00C;
	localparam logic [11:0] DLSM_OFS_ETHST    = 12'h010;
	localparam logic [11:0] DLSM_OFS_IRQST    = 12'h014;
	localparam logic [11:0] DLSM_OFS_IRQMSK   = 12'h018;
	localparam logic [11:0] DLSM_OFS_STSEL    = 12'h01C;
	localparam logic [11:0] DLSM_OFS_STCUR    = 12'h020;
	localparam logic [11:0] DLSM_OFS_STHIST   = 12'h024;
	localparam logic [11:0] DLSM_OFS_STTOT    = 12'h028;
	localparam logic [11:0] DLSM_OFS_STCUM    = 12'h02C;

	// ---------------------------------------------------------------
	// Control register fields
	// ---------------------------------------------------------------
	localparam int DLSM_CTRL_NET_TEST  = 0;
	localparam int DLSM_CTRL_LC_REQ    = 1;
	localparam int DLSM_CTRL_DLINK_EN  = 2;
	localparam int DLSM_CTRL_CUM_CLR   = 3;
	localparam int DLSM_CTRL_TR_IDLE   = 4;
	localparam int DLSM_CTRL_CARD_OK   = 5;
	localparam logic [31:0] DLSM_CTRL_RST = 32'h0000_0004;

	// Port config: bit 0 hssi enable, bit 1 v35 enable, bits 5:2 dsx enable,
	// bit 6 hssi port test, bit 7 v35 port test, bits 11:8 dsx port test.
	localparam int DLSM_PC_HSSI_EN  = 0;
	localparam int DLSM_PC_V35_EN   = 1;
	localparam int DLSM_PC_DSX_EN   = 2;
	localparam int DLSM_PC_HSSI_TST = 6;
	localparam int DLSM_PC_V35_TST  = 7;
	localparam int DLSM_PC_DSX_TST  = 8;

	// Interrupt status bits.
	localparam int DLSM_IRQ_W         = 6;
	localparam int DLSM_IRQ_HSSI_UP   = 0;
	localparam int DLSM_IRQ_HSSI_ERR  = 1;
	localparam int DLSM_IRQ_DSX_CHG   = 2;
	localparam int DLSM_IRQ_SLIP      = 3;
	localparam int DLSM_IRQ_ETH_CHG   = 4;
	localparam int DLSM_IRQ_INTERVAL  = 5;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam longint DLSM_CLK_HZ       = 125000000;
	localparam longint DLSM_INTERVAL_S   = 900;
	localparam longint DLSM_INTERVAL_CYC = DLSM_CLK_HZ * DLSM_INTERVAL_S;
	localparam int     DLSM_HIST_DEPTH   = 96;
	localparam int     DLSM_NPORT        = 4;
	localparam int     DLSM_CNT_W        = 32;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		DSX_OFF, DSX_OK, DSX_RED, DSX_OUT_OF_FRAME, DSX_YEL, DSX_BLUE, DSX_TST
	} dlsm_dsx_state_t;

	typedef enum logic [1:0] {
		LOOP_NONE, LOOP_LOCAL_LINE, LOOP_REMOTE_LINE, LOOP_LOCAL_DTE
	} dlsm_loop_t;

	typedef enum logic [1:0] {
		CARD_INIT, CARD_RUN, CARD_COMM_ERR
	} dlsm_card_t;

	typedef struct packed {
		logic ta;
		logic la;
		logic lb;
		logic txclk_ok;
	} dlsm_hssi_in_t;

	typedef struct packed {
		logic ca;
		logic lc;
		logic tm;
	} dlsm_hssi_out_t;

	typedef struct packed {
		logic tr;
		logic ll;
		logic rl;
		logic txclk_ok;
	} dlsm_v35_in_t;

	typedef struct packed {
		logic los;
		logic out_of_frame_state;
		logic yel;
		logic ais;
		logic dte;
	} dlsm_dsx_in_t;

	typedef struct packed {
		logic link;
		logic spd100;
		logic full;
	} dlsm_eth_in_t;

endpackage : dlsm_pkg

//--- hw/dlsm_stats.sv
/*
 * Statistics store: current 15-minute counters, 96-entry history,
 * rolling 24-hour totals and a cumulative count cleared only by reset or on request.
 * Assumes one event pulse per counter and an interval tick from the top.
 */
`timescale 1ns/1ns
`default_nettype none
module dlsm_stats
	import dlsm_pkg::*;
#(
	parameter int N     = 4,
	parameter int DEPTH = DLSM_HIST_DEPTH
) (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	// Events and control
	input  wire logic [N-1:0]          ev,
	input  wire logic                  tick,
	input  wire logic                  cum_clr,
	input  wire logic [1:0]            sel,
	input  wire logic [6:0]            hidx,
	// Read data
	output logic      [DLSM_CNT_W-1:0] cur_o,
	output logic      [DLSM_CNT_W-1:0] hist_o,
	output logic      [DLSM_CNT_W-1:0] tot_o,
	output logic      [DLSM_CNT_W-1:0] cum_o
);
	logic [DLSM_CNT_W-1:0] cur_q [N];
	logic [DLSM_CNT_W-1:0] cum_q [N];
	logic [DLSM_CNT_W-1:0] tot_q [N];
	logic [DLSM_CNT_W-1:0] hist_q [N][DEPTH];
	logic [6:0]            wptr_q;
	logic                  wrap_q;
	logic [6:0]            ridx;

	// Newest entry sits just behind the write pointer.
	always_comb begin
		ridx = (wptr_q > hidx) ? 7'(wptr_q - hidx - 7'h01)
			: 7'(wptr_q + 7'(DEPTH) - hidx - 7'h01);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wptr_q <= 7'h00;
			wrap_q <= 1'b0;
		end else if (tick) begin
			wptr_q <= (wptr_q == 7'(DEPTH - 1)) ? 7'h00 : 7'(wptr_q + 7'h01);
			if (wptr_q == 7'(DEPTH - 1)) wrap_q <= 1'b1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_cnt
			// Interval roll: oldest entry overwritten, current restarts.
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					cur_q[g] <= '0;
					tot_q[g] <= '0;
				end else if (tick) begin
					cur_q[g] <= {{(DLSM_CNT_W-1){1'b0}}, ev[g]};
					hist_q[g][wptr_q] <= cur_q[g];
					// Unwritten entries are unknown, so subtract only after a wrap.
					tot_q[g] <= tot_q[g] + cur_q[g]
						- (wrap_q ? hist_q[g][wptr_q] : '0);
				end else if (ev[g]) begin
					cur_q[g] <= cur_q[g] + 1'b1;
				end
			end

			always_ff @(posedge sys_clk) begin
				if (rst || cum_clr) begin
					cum_q[g] <= '0;
				end else if (ev[g]) begin
					cum_q[g] <= cum_q[g] + 1'b1;
				end
			end
		end
	endgenerate

	// History entries are undefined until written once; reads return them.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cur_o  <= '0;
			hist_o <= '0;
			tot_o  <= '0;
			cum_o  <= '0;
		end else begin
			cur_o  <= cur_q[sel];
			hist_o <= hist_q[sel][ridx];
			tot_o  <= tot_q[sel];
			cum_o  <= cum_q[sel];
		end
	end
endmodule : dlsm_stats
`default_nettype wire

//--- hw/dlsm_sync.sv
/*
 * Two-flop synchroniser for a vector of asynchronous levels.
 * Assumes inputs are slow levels from pins; no reset on the chain.
 */
`timescale 1ns/1ns
`default_nettype none
module dlsm_sync #(
	parameter int W = 1
) (
	// Clock
	input  wire logic         sys_clk,
	// Data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;

	always_ff @(posedge sys_clk) begin
		meta_q <= din;
		dout   <= meta_q;
	end
endmodule : dlsm_sync
`default_nettype wire

//--- hw/dlsm_top.sv
/*
 * DTE port lead and status monitor: HSSI and V.35 lead handling, four
 * DSX-1 port states plus card state, four Ethernet port indications,
 * alarm statistics and an APB register file with one interrupt line.
 * Assumes all pin inputs are asynchronous and one 125 MHz clock.
 */
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module dlsm_top
	import dlsm_pkg::*;
#(
	parameter longint INTERVAL_CYC = DLSM_INTERVAL_CYC,
	parameter int     NPORT        = DLSM_NPORT
) (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// HSSI leads
	input  wire dlsm_pkg::dlsm_hssi_in_t  hssi_in,
	output var dlsm_pkg::dlsm_hssi_out_t  hssi_out,
	output logic                       hssi_data_en,
	// V.35 leads
	input  wire dlsm_pkg::dlsm_v35_in_t   v35_in,
	output logic                       v35_tm,
	output logic                       v35_data_en,
	// DSX-1 ports and card
	input  wire dlsm_pkg::dlsm_dsx_in_t [NPORT-1:0] dsx_in,
	input  wire logic                  dsx_slip,
	input  wire logic                  dsx_pll_lock,
	output logic      [NPORT-1:0]      dsx_send_ais,
	// Ethernet ports
	input  wire dlsm_pkg::dlsm_eth_in_t [NPORT-1:0] eth_in,
	// Remote statistics events
	input  wire logic                  rem_alarm,
	// Interrupt
	output logic                       irq
);
	import dlsm_pkg::*;

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	localparam int SW = 4 + 4 + NPORT * 5 + 2 + NPORT * 3 + 1;
	logic [SW-1:0] raw_s;
	logic [SW-1:0] syn_s;
	dlsm_hssi_in_t            hssi_s;
	dlsm_v35_in_t             v35_s;
	dlsm_dsx_in_t [NPORT-1:0] dsx_s;
	dlsm_eth_in_t [NPORT-1:0] eth_s;
	logic slip_s;
	logic lock_s;
	logic rem_s;

	assign raw_s = {hssi_in, v35_in, dsx_in, dsx_slip, dsx_pll_lock, eth_in,
		rem_alarm};
	assign {hssi_s, v35_s, dsx_s, slip_s, lock_s, eth_s, rem_s} = syn_s;

	dlsm_sync #(.W(SW)) u_sync (
		.sys_clk (sys_clk),
		.din     (raw_s),
		.dout    (syn_s)
	);

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [31:0]          ctrl_q;
	logic [11:0]          pcfg_q;
	logic [DLSM_IRQ_W-1:0] ist_q;
	logic [DLSM_IRQ_W-1:0] imsk_q;
	logic [8:0]           stsel_q;
	logic                 wr_acc;
	logic                 rd_acc;
	logic                 cum_clr;

	assign wr_acc  = psel && penable && pwrite;
	assign rd_acc  = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign cum_clr = wr_acc && paddr == DLSM_OFS_CTRL
		&& pwdata[DLSM_CTRL_CUM_CLR];

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_q  <= DLSM_CTRL_RST;
			pcfg_q  <= '0;
			imsk_q  <= '0;
			stsel_q <= '0;
		end else if (wr_acc) begin
			case (paddr)
				DLSM_OFS_CTRL: begin
					ctrl_q <= pwdata;
					ctrl_q[DLSM_CTRL_CUM_CLR] <= 1'b0;
				end
				DLSM_OFS_PORTCFG: pcfg_q  <= pwdata[11:0];
				DLSM_OFS_IRQMSK:  imsk_q  <= pwdata[DLSM_IRQ_W-1:0];
				DLSM_OFS_STSEL:   stsel_q <= pwdata[8:0];
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// HSSI handshake and loopback leads
	// ---------------------------------------------------------------
	logic       net_test;
	logic       hssi_err;
	logic       hssi_tst;
	dlsm_loop_t hssi_loop;

	assign net_test = ctrl_q[DLSM_CTRL_NET_TEST];
	assign hssi_err = !hssi_s.txclk_ok;
	assign hssi_tst = pcfg_q[DLSM_PC_HSSI_TST];

	always_comb begin
		case ({hssi_s.la, hssi_s.lb})
			2'b10:   hssi_loop = LOOP_LOCAL_LINE;
			2'b01:   hssi_loop = LOOP_REMOTE_LINE;
			2'b11:   hssi_loop = LOOP_LOCAL_DTE;
			default: hssi_loop = LOOP_NONE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hssi_out     <= '0;
			hssi_data_en <= 1'b0;
		end else begin
			hssi_out.ca  <= pcfg_q[DLSM_PC_HSSI_EN] && !hssi_err;
			hssi_out.lc  <= ctrl_q[DLSM_CTRL_LC_REQ];
			hssi_out.tm  <= net_test || hssi_tst;
			// Both leads must be up before data flows.
			hssi_data_en <= hssi_s.ta && hssi_out.ca && !hssi_err;
		end
	end

	// ---------------------------------------------------------------
	// V.35 leads
	// ---------------------------------------------------------------
	logic v35_err;
	logic v35_tr_ok;
	logic v35_ll_q;
	logic v35_rl_q;

	assign v35_err   = !v35_s.txclk_ok;
	assign v35_tr_ok = !ctrl_q[DLSM_CTRL_TR_IDLE] || v35_s.tr;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			v35_tm      <= 1'b0;
			v35_data_en <= 1'b0;
			v35_ll_q    <= 1'b0;
			v35_rl_q    <= 1'b0;
		end else begin
			v35_tm      <= net_test || pcfg_q[DLSM_PC_V35_TST];
			v35_data_en <= pcfg_q[DLSM_PC_V35_EN] && v35_tr_ok && !v35_err;
			v35_ll_q    <= v35_s.ll;
			v35_rl_q    <= v35_s.rl;
		end
	end

	// ---------------------------------------------------------------
	// DSX-1 port and card states
	// ---------------------------------------------------------------
	dlsm_dsx_state_t [NPORT-1:0] dsx_st_q;
	logic            [NPORT-1:0] dsx_chg;
	logic            [NPORT-1:0] red_now;
	dlsm_card_t                  card_q;
	logic                        pll_err_q;

	genvar p;
	generate
		for (p = 0; p < NPORT; p++) begin : g_dsx
			dlsm_dsx_state_t nx;
			always_comb begin
				if (!pcfg_q[DLSM_PC_DSX_EN + p])
					nx = DSX_OFF;
				else if (pcfg_q[DLSM_PC_DSX_TST + p])
					nx = DSX_TST;
				else if (dsx_s[p].los)
					nx = DSX_RED;
				else if (dsx_s[p].ais)
					nx = DSX_BLUE;
				else if (dsx_s[p].out_of_frame_state)
					nx = DSX_OUT_OF_FRAME;
				else if (dsx_s[p].yel)
					nx = DSX_YEL;
				else
					nx = DSX_OK;
			end
			assign dsx_chg[p] = nx != dsx_st_q[p];
			assign red_now[p] = dsx_st_q[p] == DSX_RED;
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					dsx_st_q[p]     <= DSX_OFF;
					dsx_send_ais[p] <= 1'b0;
				end else begin
					dsx_st_q[p]     <= nx;
					dsx_send_ais[p] <= pcfg_q[DLSM_PC_DSX_EN + p]
						&& !dsx_s[p].dte;
				end
			end
		end
	endgenerate

	// Card leaves init once software reports it alive.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			card_q    <= CARD_INIT;
			pll_err_q <= 1'b0;
		end else begin
			pll_err_q <= !lock_s;
			case (card_q)
				CARD_INIT: if (ctrl_q[DLSM_CTRL_CARD_OK]) card_q <= CARD_RUN;
				CARD_RUN:  if (!ctrl_q[DLSM_CTRL_CARD_OK]) card_q <= CARD_COMM_ERR;
				CARD_COMM_ERR: if (ctrl_q[DLSM_CTRL_CARD_OK]) card_q <= CARD_RUN;
				default: card_q <= CARD_INIT;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Ethernet and interval timer
	// ---------------------------------------------------------------
	logic [3*NPORT-1:0] eth_q;
	logic [39:0]        tmr_q;
	logic               tick;

	always_ff @(posedge sys_clk) begin
		if (rst) eth_q <= '0;
		else     eth_q <= eth_s;
	end

	assign tick = tmr_q == 40'(INTERVAL_CYC - 1);

	always_ff @(posedge sys_clk) begin
		if (rst || tick) tmr_q <= '0;
		else             tmr_q <= tmr_q + 40'h1;
	end

	// ---------------------------------------------------------------
	// Statistics
	// ---------------------------------------------------------------
	logic [3:0]            ev;
	logic [DLSM_CNT_W-1:0] st_cur;
	logic [DLSM_CNT_W-1:0] st_hist;
	logic [DLSM_CNT_W-1:0] st_tot;
	logic [DLSM_CNT_W-1:0] st_cum;
	logic                  slip_q;
	logic                  rem_q;
	logic [NPORT-1:0]      red_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			slip_q <= 1'b0;
			rem_q  <= 1'b0;
			red_q  <= '0;
		end else begin
			slip_q <= slip_s;
			rem_q  <= rem_s;
			red_q  <= red_now;
		end
	end

	// Counts: red onsets, frame slips, HSSI errors, remote alarms.
	assign ev[0] = |(red_now & ~red_q);
	assign ev[1] = slip_s && !slip_q;
	assign ev[2] = hssi_err && !hssi_out.ca && pcfg_q[DLSM_PC_HSSI_EN];
	assign ev[3] = ctrl_q[DLSM_CTRL_DLINK_EN] && rem_s && !rem_q;

	dlsm_stats #(.N(4), .DEPTH(DLSM_HIST_DEPTH)) u_stats (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ev      (ev),
		.tick    (tick),
		.cum_clr (cum_clr),
		.sel     (stsel_q[1:0]),
		.hidx    (stsel_q[8:2]),
		.cur_o   (st_cur),
		.hist_o  (st_hist),
		.tot_o   (st_tot),
		.cum_o   (st_cum)
	);

	// ---------------------------------------------------------------
	// Interrupts
	// ---------------------------------------------------------------
	logic [DLSM_IRQ_W-1:0] iev;
	logic                  ist_rd;

	assign iev[DLSM_IRQ_HSSI_UP]  = hssi_s.ta && hssi_out.ca && !hssi_data_en;
	assign iev[DLSM_IRQ_HSSI_ERR] = ev[2];
	assign iev[DLSM_IRQ_DSX_CHG]  = |dsx_chg;
	assign iev[DLSM_IRQ_SLIP]     = ev[1];
	assign iev[DLSM_IRQ_ETH_CHG]  = eth_s != eth_q;
	assign iev[DLSM_IRQ_INTERVAL] = tick;
	assign ist_rd = rd_acc && paddr == DLSM_OFS_IRQST;

	// A new event in the read cycle survives the clear.
	always_ff @(posedge sys_clk) begin
		if (rst)         ist_q <= '0;
		else if (ist_rd) ist_q <= iev;
		else             ist_q <= ist_q | iev;
	end

	assign irq = |(ist_q & imsk_q);

	// ---------------------------------------------------------------
	// Read mux
	// ---------------------------------------------------------------
	logic dlink_off;
	assign dlink_off = !ctrl_q[DLSM_CTRL_DLINK_EN];

	always_comb begin
		prdata  = '0;
		pslverr = 1'b0;
		case (paddr)
			DLSM_OFS_CTRL:    prdata = ctrl_q;
			DLSM_OFS_PORTCFG: prdata = {20'h0, pcfg_q};
			DLSM_OFS_LEADS:   prdata = {20'h0, v35_rl_q, v35_ll_q, v35_s.tr,
				v35_err, hssi_err, hssi_loop, hssi_out.tm, hssi_out.lc,
				hssi_out.ca, hssi_s.ta, hssi_data_en};
			DLSM_OFS_DSXST:   prdata = {4'h0, pll_err_q, slip_q, card_q,
				8'h0, dsx_send_ais, 12'(dsx_st_q)};
			DLSM_OFS_ETHST:   prdata = {20'h0, eth_q};
			DLSM_OFS_IRQST:   prdata = {26'h0, ist_q};
			DLSM_OFS_IRQMSK:  prdata = {26'h0, imsk_q};
			DLSM_OFS_STSEL:   prdata = {23'h0, stsel_q};
			// Remote channel reads zero for current, history and total while the data link is off; cumulative still reads.
			DLSM_OFS_STCUR:   prdata = (dlink_off && stsel_q[1:0] == 2'h3)
				? '0 : st_cur;
			DLSM_OFS_STHIST:  prdata = (dlink_off && stsel_q[1:0] == 2'h3)
				? '0 : st_hist;
			DLSM_OFS_STTOT:   prdata = (dlink_off && stsel_q[1:0] == 2'h3)
				? '0 : st_tot;
			DLSM_OFS_STCUM:   prdata = st_cum;
			default:          pslverr = psel && penable;
		endcase
	end

endmodule : dlsm_top
`default_nettype wire

//--- sim/dlsm_chk.sv
/* Port checker for the lead and status monitor.
 * Assumes one clock and a three-cycle lag from pin to output. */
`timescale 1ns/1ns
`default_nettype none
module dlsm_chk
	import dlsm_pkg::*;
#(
	parameter int NPORT = DLSM_NPORT
) (
	// Clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     rst,
	// APB
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              prdata,
	input  wire logic                     pready,
	input  wire logic                     pslverr,
	// Leads and status
	input  wire dlsm_pkg::dlsm_hssi_in_t  hssi_in,
	input  wire dlsm_pkg::dlsm_hssi_out_t hssi_out,
	input  wire logic                     hssi_data_en,
	input  wire dlsm_pkg::dlsm_v35_in_t   v35_in,
	input  wire logic                     v35_data_en,
	input  wire dlsm_pkg::dlsm_dsx_in_t [NPORT-1:0] dsx_in,
	input  wire logic [NPORT-1:0]         dsx_send_ais,
	input  wire logic                     irq
);
	import dlsm_pkg::*;
	logic [NPORT-1:0] dte_v;
	logic             mapped;
	always_comb begin
		for (int i = 0; i < NPORT; i++) begin
			dte_v[i] = dsx_in[i].dte;
		end
	end
	assign mapped = paddr <= DLSM_OFS_STCUM && paddr[1:0] == 2'h0;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence apb_acc;
		psel && penable;
	endsequence
	pready_high_a: assert property (pready) else $error("pready low");
	map_ok_a: assert property (apb_acc and mapped |-> !pslverr)
		else $error("error on mapped access");
	unmap_err_a: assert property (apb_acc and !mapped |-> pslverr
		&& (pwrite || prdata == 32'h0000_0000)) else $error("bad unmapped");
	data_gate_a: assert property (hssi_data_en |-> $past(hssi_in.ta, 3))
		else $error("hssi data without ta");
	clk_fault_a: assert property (hssi_data_en || v35_data_en |->
		$past(hssi_in.txclk_ok, 3) || !hssi_data_en) else $error("data on lost clock");
	ais_dte_a: assert property ((dsx_send_ais & $past(dte_v, 3)) == '0)
		else $error("ais sent to attached port");
	rst_clear_a: assert property (disable iff (1'b0) $fell(rst) |-> !irq
		&& hssi_out == '0 && !hssi_data_en && dsx_send_ais == '0)
		else $error("outputs not cleared by reset");
	irq_clr_a: assert property (apb_acc and !pwrite && paddr == DLSM_OFS_IRQST
		|=> !irq) else $error("irq stays after status read");
endmodule : dlsm_chk
`default_nettype wire
bind dlsm_top dlsm_chk #(.NPORT(NPORT)) i_dlsm_chk (.sys_clk(sys_clk),
	.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.hssi_in(hssi_in), .hssi_out(hssi_out), .hssi_data_en(hssi_data_en),
	.v35_in(v35_in), .v35_data_en(v35_data_en), .dsx_in(dsx_in),
	.dsx_send_ais(dsx_send_ais), .irq(irq));

//--- sim/dlsm_dte_model.sv
/* Terminal equipment model on the HSSI and V.35 leads.
 * Assumes the bench commands it; all leads are driven as levels. */
`timescale 1ns/1ns
`default_nettype none
module dlsm_dte_model
	import dlsm_pkg::*;
(
	// Clock
	input  wire logic                     sys_clk,
	// Commands from the bench
	input  wire logic                     ready,
	input  wire logic                     clk_ok,
	input  wire dlsm_pkg::dlsm_loop_t     loop,
	input  wire logic [2:0]               v35_ctl,
	// Device leads
	output var  dlsm_pkg::dlsm_hssi_in_t  hssi_in,
	output var  dlsm_pkg::dlsm_v35_in_t   v35_in
);
	import dlsm_pkg::*;
	always_ff @(posedge sys_clk) begin
		hssi_in.ta       <= ready;
		hssi_in.la       <= loop == LOOP_LOCAL_LINE || loop == LOOP_LOCAL_DTE;
		hssi_in.lb       <= loop == LOOP_REMOTE_LINE || loop == LOOP_LOCAL_DTE;
		hssi_in.txclk_ok <= clk_ok;
		v35_in           <= {v35_ctl, clk_ok};
	end
endmodule : dlsm_dte_model
`default_nettype wire

//--- sim/dlsm_top_test.sv
/* Register level testbench for the lead and status monitor.
 * Assumes zero wait APB and a three-cycle pin lag. */
`timescale 1ns/1ns
`default_nettype none
module dlsm_top_test;
	import dlsm_pkg::*;
	logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq, err, rdy;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic ready, clk_ok, hssi_data_en, v35_tm, v35_data_en, slip, lock, ral;
	logic [2:0] v35_ctl;
	logic [3:0] send_ais;
	dlsm_loop_t loop;
	dlsm_hssi_in_t hssi_in;
	dlsm_hssi_out_t hssi_out;
	dlsm_v35_in_t v35_in;
	dlsm_dsx_in_t [3:0] dsx_in;
	dlsm_eth_in_t [3:0] eth_in;
	int bad_count, total_checks, cyc;
	dlsm_top #(.INTERVAL_CYC(400)) i_dlsm_top (.sys_clk(sys_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hssi_in(hssi_in), .hssi_out(hssi_out), .hssi_data_en(hssi_data_en),
		.v35_in(v35_in), .v35_tm(v35_tm), .v35_data_en(v35_data_en),
		.dsx_in(dsx_in), .dsx_slip(slip), .dsx_pll_lock(lock),
		.dsx_send_ais(send_ais), .eth_in(eth_in), .rem_alarm(ral), .irq(irq));
	dlsm_dte_model i_dlsm_dte_model (.sys_clk(sys_clk), .ready(ready),
		.clk_ok(clk_ok), .loop(loop), .v35_ctl(v35_ctl), .hssi_in(hssi_in),
		.v35_in(v35_in));
	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : results
	task automatic check(input string n, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Answer is settled mid-cycle and stands until the completing edge.
		do begin
			@(negedge sys_clk);
			rdy = pready;
			rdata = prdata;
			err = pslverr;
			@(posedge sys_clk);
		end while (rdy !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input string n, input logic [11:0] a, input logic [31:0] m, e);
		apb(1'b0, a, 32'h0000_0000);
		check(n, rdata & m, e);
	endtask : rd
	task automatic settle;
		repeat (6) @(posedge sys_clk);
	endtask : settle
	task automatic pulse2;
		repeat (2) begin
			ral <= 1'b1;
			repeat (4) @(posedge sys_clk);
			ral <= 1'b0;
			repeat (4) @(posedge sys_clk);
		end
		settle();
	endtask : pulse2
	task automatic wait_irq;
		for (int i = 0; i < 900 && irq !== 1'b1; i++) @(posedge sys_clk);
		rd("interval", DLSM_OFS_IRQST, 32'h0000_0020, 32'h0000_0020);
	endtask : wait_irq
	// ---------------------------------------------------------------
	// Clock, timeout and tests
	// ---------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			results();
		end
	end
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata, cyc} = '0;
		{bad_count, total_checks, slip, ral} = '0;
		{rst, ready, clk_ok, lock, v35_ctl} = {4'hF, 3'h0};
		loop = LOOP_NONE;
		dsx_in = {4{5'h01}};
		eth_in = '0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd("ctrl reset", DLSM_OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0004);
		rd("cfg reset", DLSM_OFS_PORTCFG, 32'hFFFF_FFFF, 32'h0000_0000);
		rd("card init", DLSM_OFS_DSXST, 32'h0300_0000, 32'h0000_0000);
		rd("unmapped", 12'h030, 32'hFFFF_FFFF, 32'h0000_0000);
		check("unmapped err", {31'h0, err}, 32'h1);
		for (int l = 0; l < 4; l++) begin
			loop <= dlsm_loop_t'(l);
			settle();
			rd("loop", DLSM_OFS_LEADS, 32'h0000_0060, 32'(l) << 5);
		end
		wr(DLSM_OFS_PORTCFG, 32'h0000_0003);
		settle();
		check("ca and data", {hssi_out.ca, hssi_data_en}, 32'h3);
		ready <= 1'b0;
		settle();
		check("no ta", {31'h0, hssi_data_en}, 32'h0);
		{ready, clk_ok} <= 2'b10;
		settle();
		check("clock lost", {hssi_data_en, v35_data_en}, 32'h0);
		clk_ok <= 1'b1;
		wr(DLSM_OFS_CTRL, 32'h0000_0007);
		settle();
		check("tm lc", {hssi_out.tm, v35_tm, hssi_out.lc}, 32'h7);
		wr(DLSM_OFS_CTRL, 32'h0000_0004);
		wr(DLSM_OFS_PORTCFG, 32'h0000_0043);
		settle();
		check("port tm", {hssi_out.tm, v35_tm, hssi_out.lc}, 32'h4);
		check("tr ignored", {31'h0, v35_data_en}, 32'h1);
		wr(DLSM_OFS_CTRL, 32'h0000_0014);
		settle();
		check("tr needed", {31'h0, v35_data_en}, 32'h0);
		v35_ctl <= 3'h4;
		settle();
		check("tr given", {31'h0, v35_data_en}, 32'h1);
		dsx_in <= {5'h05, 5'h09, 5'h11, 5'h01};
		wr(DLSM_OFS_PORTCFG, 32'h0000_0038);
		settle();
		rd("dsx alarms", DLSM_OFS_DSXST, 32'h0000_0FFF, 32'h0000_08D0);
		dsx_in <= {5'h00, 5'h03, 5'h01, 5'h01};
		wr(DLSM_OFS_PORTCFG, 32'h0000_013C);
		settle();
		rd("dsx blue", DLSM_OFS_DSXST, 32'h0000_F1FF, 32'h0000_814E);
		check("ais pins", {28'h0, send_ais}, 32'h8);
		wr(DLSM_OFS_CTRL, 32'h0000_0024);
		{slip, lock} <= 2'b10;
		settle();
		rd("card run", DLSM_OFS_DSXST, 32'h0F00_0000, 32'h0D00_0000);
		wr(DLSM_OFS_CTRL, 32'h0000_0004);
		rd("card comm", DLSM_OFS_DSXST, 32'h0300_0000, 32'h0200_0000);
		wr(DLSM_OFS_IRQMSK, 32'h0000_0010);
		rd("irq clear", DLSM_OFS_IRQST, 32'h0000_0000, 32'h0000_0000);
		eth_in[0] <= 3'h7;
		settle();
		check("irq set", {31'h0, irq}, 32'h1);
		rd("eth event", DLSM_OFS_IRQST, 32'h0000_0010, 32'h0000_0010);
		wr(DLSM_OFS_IRQMSK, 32'h0000_0000);
		eth_in[0] <= 3'h4;
		settle();
		check("irq masked", {31'h0, irq}, 32'h0);
		rd("masked sticky", DLSM_OFS_IRQST, 32'h0000_0010, 32'h0000_0010);
		wr(DLSM_OFS_IRQMSK, 32'h0000_0020);
		wr(DLSM_OFS_STSEL, 32'h0000_0003);
		wait_irq();
		pulse2();
		rd("cur", DLSM_OFS_STCUR, 32'hFFFF_FFFF, 32'h0000_0002);
		rd("cum", DLSM_OFS_STCUM, 32'hFFFF_FFFF, 32'h0000_0002);
		wait_irq();
		rd("hist", DLSM_OFS_STHIST, 32'hFFFF_FFFF, 32'h0000_0002);
		rd("cur restart", DLSM_OFS_STCUR, 32'hFFFF_FFFF, 32'h0000_0000);
		rd("total", DLSM_OFS_STTOT, 32'hFFFF_FFFF, 32'h0000_0002);
		wr(DLSM_OFS_CTRL, 32'h0000_000C);
		rd("cum clear", DLSM_OFS_STCUM, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(DLSM_OFS_CTRL, 32'h0000_0000);
		pulse2();
		rd("no remote", DLSM_OFS_STCUM, 32'hFFFF_FFFF, 32'h0000_0000);
		results();
	end
endmodule : dlsm_top_test
`default_nettype wire
